// file: logic/dbm_command_mux.v
// Command interpreter of the calibration carrier board
//
// Behaviour
// (R1) Link is 19200 baud, eight data bits, one stop bit, no parity.
// (R2) Commands arrive on the receive pin; replies leave on the reply pin.
// (R3) Act only on commands for the own address or the broadcast address.
// (R4) Version query for own address returns the version string; others stay silent.
// (R5) Up to eight boards chained; address zero sits next to the controller.
// (R6) Address read from jumpers inverted; open jumper reads zero.
// (R7) Three LEDs show the jumper address.
// (R8) Address digit nine is broadcast, executed by every board.
// (R9) Interface select one picks one-wire, zero picks I2C.
// (R10) Select lines high,low: 00 I2C, 01 one-wire, 10 LIN, 11 none.
// (R11) Port-set drives the named select line to zero or one.
// (R12) Controller sets both select ports before any interface command.
// (R13) Board only switches DUT power and selects the interface.
// (R14) Twenty-four DUT positions, each with its own switched supply.
// (R15) Each DUT supply is switched on or off by command.
// (R16) Frames are X, address, command, arguments, colon X; others discarded.
// (R17) After reset both select lines are low, selecting I2C.
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.vh"

module dbm_command_mux (
    input wire clk_sys, // System clock, 10 MHz
    input wire reset, // Synchronous reset, active high
    input wire rx_pin, // Command receive line
    input wire [2:0] address_jumper_block, // Jumper pins, high when open
    output wire reply_and_select_high_pin, // Serial reply line, idle high
    output wire select_high_port, // Interface mux select, high line
    output wire select_low_port, // Interface mux select, low line
    output wire address_led_a, // Address bit 0 indicator
    output wire address_led_b, // Address bit 1 indicator
    output wire address_led_c, // Address bit 2 indicator
    output wire [`DBM_DUT_COUNT-1:0] dut_power_en, // Per-DUT supply enable
    output wire reply_busy // High while a reply is being sent
);
    localparam integer BIT_CYC_INT = `DBM_BIT_CYCLES;
    localparam [9:0] BIT_CYC = BIT_CYC_INT[9:0];
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_BODY = 3'b010;
    localparam [2:0] ST_TERM = 3'b100;
    // Reply text; value is arbitrary
    localparam [63:0] VERSION_TEXT = 64'h5632_2E30_3162_0D0A;

    wire [7:0] rx_data;
    wire rx_valid;

    reg [2:0] jmp_sync1_reg;
    reg [2:0] jmp_sync2_reg;
    reg [2:0] own_addr_reg;
    reg [2:0] state_reg;
    reg [63:0] buf_reg;
    reg [3:0] len_reg;
    reg sel_high_reg;
    reg sel_low_reg;
    reg [`DBM_DUT_COUNT-1:0] power_reg;
    reg tx_active_reg;
    reg tx_line_reg;
    reg [9:0] tx_cnt_reg;
    reg [3:0] tx_bits_reg;
    reg [8:0] tx_shift_reg;
    reg [3:0] tx_idx_reg;

    function [7:0] byte_at;
        input [63:0] b;
        input [2:0] i;
        begin
            byte_at = b[i*8 +: 8];
        end
    endfunction

    function is_bit_char;
        input [7:0] ch;
        begin
            is_bit_char = (ch == `DBM_CH_ZERO) || (ch == `DBM_CH_ONE);
        end
    endfunction

    function is_digit;
        input [7:0] ch;
        begin
            is_digit = (ch[7:4] == 4'h3) && (ch[3:0] <= 4'h9);
        end
    endfunction

    function [7:0] ver_char;
        input [3:0] idx;
        begin
            ver_char = VERSION_TEXT[(7 - idx[2:0])*8 +: 8];
        end
    endfunction

    dbm_uart_rx u_rx (
        .clk_sys(clk_sys),
        .reset(reset),
        .rx_pin(rx_pin), // R2
        .rx_data(rx_data),
        .rx_valid(rx_valid)
    );

    wire [7:0] b0 = byte_at(buf_reg, 3'd0);
    wire [7:0] b1 = byte_at(buf_reg, 3'd1);
    wire [7:0] b2 = byte_at(buf_reg, 3'd2);
    wire [7:0] b3 = byte_at(buf_reg, 3'd3);
    wire [7:0] b4 = byte_at(buf_reg, 3'd4);
    wire [7:0] b5 = byte_at(buf_reg, 3'd5);
    wire [7:0] b6 = byte_at(buf_reg, 3'd6);
    wire [7:0] own_digit = {5'b00110, own_addr_reg};
    wire own_hit = (b0 == own_digit);
    wire addr_hit = own_hit || (b0 == `DBM_CH_BCAST); // R3 R8
    wire frame_done = (state_reg == ST_TERM) && rx_valid && (rx_data == `DBM_CH_FRAME); // R16

    wire cmd_ver = (len_reg == `DBM_LEN_VER) && (b1 == `DBM_CH_V) && own_hit; // R4
    wire cmd_sel = (len_reg == `DBM_LEN_SEL) && (b1 == `DBM_CH_C) && (b2 == `DBM_CH_Z)
        && is_bit_char(b3) && addr_hit;
    wire cmd_port = (len_reg == `DBM_LEN_PORT) && (b1 == `DBM_CH_P) && (b2 == `DBM_CH_S)
        && (b3 == `DBM_CH_UNDER) && (b4 == `DBM_CH_D)
        && ((b5 == `DBM_CH_TWO) || (b5 == `DBM_CH_THREE)) && is_bit_char(b6) && addr_hit;
    wire [6:0] pw_num = {3'b000, b3[3:0]} * 7'h0a + {3'b000, b4[3:0]};
    wire [6:0] pw_idx = pw_num - 7'h01;
    wire cmd_pwr = (len_reg == `DBM_LEN_PWR) && (b1 == `DBM_CH_P) && (b2 == `DBM_CH_W)
        && is_digit(b3) && is_digit(b4) && is_bit_char(b5) && addr_hit
        && (pw_num != 7'h00) && (pw_num <= 7'd24); // R14

    assign reply_and_select_high_pin = tx_line_reg; // R2
    assign select_high_port = sel_high_reg;
    assign select_low_port = sel_low_reg;
    assign address_led_a = own_addr_reg[0]; // R7
    assign address_led_b = own_addr_reg[1]; // R7
    assign address_led_c = own_addr_reg[2]; // R7
    assign dut_power_en = power_reg;
    assign reply_busy = tx_active_reg;

    // Jumper pins are asynchronous straps
    always @(posedge clk_sys) begin
        if (reset) begin
            jmp_sync1_reg <= 3'b111;
            jmp_sync2_reg <= 3'b111;
            own_addr_reg <= 3'b000;
        end else begin
            jmp_sync1_reg <= address_jumper_block;
            jmp_sync2_reg <= jmp_sync1_reg;
            own_addr_reg <= ~jmp_sync2_reg; // R6 R5
        end
    end

    // Frame parser
    always @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            buf_reg <= 64'h0000_0000_0000_0000;
            len_reg <= 4'h0;
        end else if (rx_valid) begin
            case (state_reg)
                ST_IDLE: begin
                    if (rx_data == `DBM_CH_FRAME) begin // R16
                        state_reg <= ST_BODY;
                        len_reg <= 4'h0;
                    end
                end
                ST_BODY: begin
                    if (rx_data == `DBM_CH_FRAME) begin
                        // A fresh X restarts the frame
                        len_reg <= 4'h0;
                    end else if (rx_data == `DBM_CH_COLON) begin
                        state_reg <= ST_TERM;
                    end else if (len_reg == `DBM_BUF_BYTES) begin
                        state_reg <= ST_IDLE; // R16
                    end else begin
                        buf_reg[len_reg[2:0]*8 +: 8] <= rx_data;
                        len_reg <= len_reg + 4'h1;
                    end
                end
                ST_TERM: begin
                    state_reg <= ST_IDLE; // R16
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Command execution; only mux select and DUT power are steered here
    always @(posedge clk_sys) begin
        if (reset) begin
            sel_high_reg <= 1'b0; // R17
            sel_low_reg <= 1'b0; // R17
            power_reg <= {`DBM_DUT_COUNT{1'b0}};
        end else if (frame_done) begin // R13
            if (cmd_sel) begin
                // 00 or 01 only; LIN needs port-set
                sel_high_reg <= 1'b0; // R9 R10
                sel_low_reg <= b3[0]; // R9 R10
            end
            if (cmd_port) begin // R11 R12
                if (b5 == `DBM_CH_TWO) begin
                    sel_low_reg <= b6[0]; // R11 R10
                end else begin
                    sel_high_reg <= b6[0]; // R11 R10
                end
            end
            if (cmd_pwr) begin
                power_reg[pw_idx[4:0]] <= b5[0]; // R15
            end
        end
    end

    // Reply transmitter; a query during a reply is dropped
    always @(posedge clk_sys) begin
        if (reset) begin
            tx_active_reg <= 1'b0;
            tx_line_reg <= 1'b1;
            tx_cnt_reg <= 10'h000;
            tx_bits_reg <= 4'h0;
            tx_shift_reg <= 9'h1ff;
            tx_idx_reg <= 4'h0;
        end else if (!tx_active_reg) begin
            if (frame_done && cmd_ver) begin // R4
                tx_active_reg <= 1'b1;
                tx_idx_reg <= 4'h0;
                tx_line_reg <= 1'b0;
                tx_shift_reg <= {1'b1, ver_char(4'h0)};
                tx_bits_reg <= 4'h9;
                tx_cnt_reg <= BIT_CYC - 10'h001;
            end
        end else if (tx_cnt_reg != 10'h000) begin
            tx_cnt_reg <= tx_cnt_reg - 10'h001;
        end else if (tx_bits_reg != 4'h0) begin
            tx_line_reg <= tx_shift_reg[0]; // R1
            tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
            tx_bits_reg <= tx_bits_reg - 4'h1;
            tx_cnt_reg <= BIT_CYC - 10'h001;
        end else if (tx_idx_reg + 4'h1 < `DBM_VER_LEN) begin
            tx_idx_reg <= tx_idx_reg + 4'h1;
            tx_line_reg <= 1'b0;
            tx_shift_reg <= {1'b1, ver_char(tx_idx_reg + 4'h1)};
            tx_bits_reg <= 4'h9;
            tx_cnt_reg <= BIT_CYC - 10'h001;
        end else begin
            tx_active_reg <= 1'b0;
        end
    end
endmodule // dbm_command_mux
`default_nettype wire

// file: shared/dbm_defs.vh
// Constants for the board command multiplexer
`ifndef DBM_DEFS_VH
`define DBM_DEFS_VH

// Timing
`define DBM_CLK_HZ 10000000
`define DBM_BAUD 19200
`define DBM_BIT_CYCLES ((`DBM_CLK_HZ + (`DBM_BAUD / 2)) / `DBM_BAUD)
`define DBM_HALF_CYCLES (`DBM_BIT_CYCLES / 2)

// Frame characters
`define DBM_CH_FRAME 8'h58
`define DBM_CH_COLON 8'h3a
`define DBM_CH_ZERO 8'h30
`define DBM_CH_ONE 8'h31
`define DBM_CH_TWO 8'h32
`define DBM_CH_THREE 8'h33
`define DBM_CH_BCAST 8'h39
`define DBM_CH_V 8'h56
`define DBM_CH_C 8'h43
`define DBM_CH_Z 8'h5a
`define DBM_CH_P 8'h50
`define DBM_CH_S 8'h53
`define DBM_CH_W 8'h57
`define DBM_CH_UNDER 8'h5f
`define DBM_CH_D 8'h44

// Frame body lengths (address digit included)
`define DBM_LEN_VER 4'h2
`define DBM_LEN_SEL 4'h4
`define DBM_LEN_PWR 4'h6
`define DBM_LEN_PORT 4'h7
`define DBM_BUF_BYTES 4'h8

// Interface select codes, high line then low line
`define DBM_SEL_I2C 2'b00
`define DBM_SEL_ONE_WIRE 2'b01
`define DBM_SEL_LIN 2'b10
`define DBM_SEL_NONE 2'b11

// DUT power and version reply
`define DBM_DUT_COUNT 24
`define DBM_VER_LEN 4'h8

`endif

// file: logic/dbm_uart_rx.v
// Serial receiver, 8N1, with input synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.vh"

module dbm_uart_rx (
    input wire clk_sys, // System clock
    input wire reset, // Synchronous reset, active high
    input wire rx_pin, // Serial line from the pin
    output wire [7:0] rx_data, // Received byte
    output wire rx_valid // One-cycle pulse per good byte
);
    // Header counts are 32-bit integers; keep the ten bits the counter holds
    localparam integer BIT_CYC_INT = `DBM_BIT_CYCLES;
    localparam integer HALF_CYC_INT = `DBM_HALF_CYCLES;
    localparam [9:0] BIT_CYC = BIT_CYC_INT[9:0];
    localparam [9:0] HALF_CYC = HALF_CYC_INT[9:0];

    reg sync1_reg;
    reg sync2_reg;
    reg busy_reg;
    reg [9:0] cnt_reg;
    reg [3:0] bit_reg;
    reg [7:0] shift_reg;
    reg [7:0] data_reg;
    reg valid_reg;

    assign rx_data = data_reg;
    assign rx_valid = valid_reg;

    always @(posedge clk_sys) begin
        if (reset) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            busy_reg <= 1'b0;
            cnt_reg <= 10'h000;
            bit_reg <= 4'h0;
            shift_reg <= 8'h00;
            data_reg <= 8'h00;
            valid_reg <= 1'b0;
        end else begin
            sync1_reg <= rx_pin;
            sync2_reg <= sync1_reg;
            valid_reg <= 1'b0;
            if (!busy_reg) begin
                if (!sync2_reg) begin // R1
                    busy_reg <= 1'b1;
                    cnt_reg <= HALF_CYC;
                    bit_reg <= 4'h0;
                end
            end else if (cnt_reg != 10'h000) begin
                cnt_reg <= cnt_reg - 10'h001;
            end else begin
                cnt_reg <= BIT_CYC - 10'h001;
                if (bit_reg == 4'h0) begin
                    // Glitch shorter than half a bit is not a start
                    if (sync2_reg) begin
                        busy_reg <= 1'b0;
                    end
                    bit_reg <= 4'h1;
                end else if (bit_reg < 4'h9) begin
                    shift_reg <= {sync2_reg, shift_reg[7:1]}; // R1
                    bit_reg <= bit_reg + 4'h1;
                end else begin
                    busy_reg <= 1'b0;
                    // Missing stop bit drops the byte
                    if (sync2_reg) begin // R1
                        data_reg <= shift_reg;
                        valid_reg <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // dbm_uart_rx
`default_nettype wire

// file: dv/dbm_assertions.sv
// Port checker for the board command multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.vh"
module dbm_assertions (
    input wire clk_sys, // Clock
    input wire reset, // Reset
    input wire rx_pin, // Command line
    input wire [2:0] address_jumper_block, // Jumpers
    input wire reply_and_select_high_pin, // Reply line
    input wire select_high_port, // Select high
    input wire select_low_port, // Select low
    input wire address_led_a, // LED bit 0
    input wire address_led_b, // LED bit 1
    input wire address_led_c, // LED bit 2
    input wire [`DBM_DUT_COUNT-1:0] dut_power_en, // Supplies
    input wire reply_busy // Reply active
);
    logic [15:0] low_reg;
    logic [15:0] busy_reg;
    // Run lengths of reply low level and of busy
    always @(posedge clk_sys) begin
        low_reg <= reply_and_select_high_pin ? 16'h0000 : low_reg + 16'h0001;
        busy_reg <= reply_busy ? busy_reg + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_jmp_steady;
        $stable(address_jumper_block) [*5];
    endsequence
    // Select and power outputs only move while the stop bit of the closing character stands
    sequence s_quiet_rx;
        rx_pin && $past(rx_pin, 8);
    endsequence
    a_reset_sel_i2c: assert property (disable iff (1'b0) reset |=> !select_high_port && !select_low_port)
        else $error("select lines not low after reset");
    a_reset_idle: assert property (disable iff (1'b0) reset |=> reply_and_select_high_pin && !reply_busy
        && dut_power_en == 24'h00_0000) else $error("reply or power not idle after reset");
    a_led_address: assert property (s_jmp_steady |-> {address_led_c, address_led_b, address_led_a}
        == ~address_jumper_block) else $error("address LEDs wrong");
    a_idle_high: assert property (!reply_busy |-> reply_and_select_high_pin)
        else $error("reply line low while idle");
    a_reply_in_busy: assert property ($fell(reply_and_select_high_pin) |-> reply_busy)
        else $error("reply start without busy");
    a_bit_length: assert property ($rose(reply_and_select_high_pin) && reply_busy |->
        low_reg != 16'h0000 && low_reg % `DBM_BIT_CYCLES == 0) else $error("reply bit length wrong");
    a_reply_length: assert property ($fell(reply_busy) |-> busy_reg >= 80 * `DBM_BIT_CYCLES
        && busy_reg <= 80 * `DBM_BIT_CYCLES + 2) else $error("reply length wrong");
    a_sel_on_stop: assert property ($changed({select_high_port, select_low_port}) |-> s_quiet_rx)
        else $error("select changed outside a frame end");
    a_power_on_stop: assert property ($changed(dut_power_en) |-> s_quiet_rx)
        else $error("power changed outside a frame end");
endmodule // dbm_assertions
bind dbm_command_mux dbm_assertions u_chk (.clk_sys(clk_sys), .reset(reset), .rx_pin(rx_pin),
    .address_jumper_block(address_jumper_block), .reply_and_select_high_pin(reply_and_select_high_pin),
    .select_high_port(select_high_port), .select_low_port(select_low_port), .address_led_a(address_led_a),
    .address_led_b(address_led_b), .address_led_c(address_led_c), .dut_power_en(dut_power_en),
    .reply_busy(reply_busy));
`default_nettype wire

// file: dv/dbm_host_model.sv
// Upstream controller model: sends command frames, captures replies
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.vh"
module dbm_host_model (
    input wire clk_sys, // System clock
    input wire reply_line, // Board reply input
    output logic cmd_line // Command line to the board
);
    logic [7:0] got_q[$];
    logic [7:0] byte_v;
    logic bad_stop;
    initial cmd_line = 1'b1;
    task automatic send_frame(input string s);
        logic [9:0] bits;
        for (int k = 0; k < s.len(); k++) begin
            bits = {1'b1, s[k], 1'b0};
            for (int i = 0; i < 10; i++) begin
                @(negedge clk_sys);
                cmd_line = bits[i];
                repeat (`DBM_BIT_CYCLES - 1) @(negedge clk_sys);
            end
        end
    endtask
    // Sampling on the falling edge keeps clear of the board's register updates
    initial begin
        bad_stop = 1'b0;
        forever begin
            @(negedge reply_line);
            repeat (`DBM_HALF_CYCLES) @(negedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (`DBM_BIT_CYCLES) @(negedge clk_sys);
                byte_v[i] = reply_line;
            end
            repeat (`DBM_BIT_CYCLES) @(negedge clk_sys);
            if (reply_line !== 1'b1) bad_stop = 1'b1;
            got_q.push_back(byte_v);
        end
    end
endmodule // dbm_host_model
`default_nettype wire

// file: dv/tb_dut_board_command_mux.sv
// Self-checking bench for the board command multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "dbm_defs.vh"
module tb_dut_board_command_mux;
    logic clk_sys;
    logic reset;
    wire rx_pin;
    logic [2:0] address_jumper_block;
    wire reply_and_select_high_pin;
    wire select_high_port;
    wire select_low_port;
    wire address_led_a;
    wire address_led_b;
    wire address_led_c;
    wire [`DBM_DUT_COUNT-1:0] dut_power_en;
    wire reply_busy;
    wire [1:0] sel_pair = {select_high_port, select_low_port};
    int failures;
    int checks;
    string want;
    dbm_command_mux dut (.clk_sys(clk_sys), .reset(reset), .rx_pin(rx_pin),
        .address_jumper_block(address_jumper_block), .reply_and_select_high_pin(reply_and_select_high_pin),
        .select_high_port(select_high_port), .select_low_port(select_low_port), .address_led_a(address_led_a),
        .address_led_b(address_led_b), .address_led_c(address_led_c), .dut_power_en(dut_power_en),
        .reply_busy(reply_busy));
    dbm_host_model host (.clk_sys(clk_sys), .reply_line(reply_and_select_high_pin), .cmd_line(rx_pin));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic sel_case(input string s, input logic [1:0] exp);
        host.send_frame(s);
        check(sel_pair, exp, s);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Frames take milliseconds at this baud rate, so the limit is generous
    initial begin
        #80_000_000;
        failures++;
        report_and_stop();
    end
    initial begin
        reset = 1'b1;
        address_jumper_block = 3'h4;
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
        host.got_q.delete();
        check({address_led_c, address_led_b, address_led_a}, 3'h3, "leds");
        check(sel_pair, `DBM_SEL_I2C, "reset sel");
        check(dut_power_en, 24'h00_0000, "reset power");
        sel_case("X9CZ1:X", `DBM_SEL_ONE_WIRE);
        sel_case("X5CZ0:X", `DBM_SEL_ONE_WIRE);
        sel_case("X3CZ0:X", `DBM_SEL_I2C);
        sel_case("X9PS_D31:X", `DBM_SEL_LIN);
        sel_case("X3PS_D21:X", `DBM_SEL_NONE);
        sel_case("X9CZ1;X", `DBM_SEL_NONE);
        sel_case("X9PS_D30:X", `DBM_SEL_ONE_WIRE);
        host.send_frame("X3PW241:X");
        check(dut_power_en, 24'h80_0000, "power on");
        host.send_frame("X3PW001:X");
        check(dut_power_en, 24'h80_0000, "bad dut");
        host.send_frame("X9PW240:X");
        check(dut_power_en, 24'h00_0000, "power off");
        host.send_frame("X5V:X");
        check(reply_busy, 1'b0, "silent busy");
        // A wrong reply needs a full character time to reach the queue
        repeat (6000) @(negedge clk_sys);
        check(host.got_q.size(), 32'h0000_0000, "silent");
        host.send_frame("X3V:X");
        for (int i = 0; i < 45000 && host.got_q.size() < 8; i++) @(negedge clk_sys);
        check(host.got_q.size(), 32'h0000_0008, "reply count");
        want = "V2.01b\r\n";
        for (int i = 0; i < 8; i++) begin
            check(host.got_q[i], want[i], "reply char");
        end
        check(host.bad_stop, 1'b0, "stop bit");
        // Let the reply end, then reset mid-run with one-wire still selected
        repeat (600) @(negedge clk_sys);
        check(reply_busy, 1'b0, "reply end");
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
        check(sel_pair, `DBM_SEL_I2C, "mid reset sel");
        check(reply_and_select_high_pin, 1'b1, "mid reset reply");
        check({address_led_c, address_led_b, address_led_a}, 3'h3, "mid reset leds");
        report_and_stop();
    end
endmodule // tb_dut_board_command_mux
`default_nettype wire
